// File: core/wdlrs_top.sv
// Watchdog timer with lock, immediate reload and debug stall
`timescale 1ns/1ps
module wdlrs_top (
   input  wire logic        mclk_in,
   input  wire logic        rst_n_in,
   input  wire logic        ce_in,
   input  wire logic        lock_in,
   input  wire logic        unlock_in,
   input  wire logic        enable_in,
   input  wire logic        int_clear_in,
   input  wire logic        int_en_in,
   input  wire logic        reset_en_set_in,
   input  wire logic        reset_en_clr_in,
   input  wire logic        stall_en_in,
   input  wire logic        reload_wr_in,
   input  wire logic [31:0] reload_value_in,
   input  wire logic        gated_status_select_in,
   input  wire logic        debug_halt_in,
   output logic             int_status_out,
   output logic             irq_out,
   output logic             sys_reset_out,
   output logic             locked_out,
   output logic             running_out,
   output logic             reset_en_out,
   output logic             stall_en_out,
   output logic [31:0]      reload_value_out,
   output logic [31:0]      count_out
);
   import wdlrs_pkg::*;

   wdlrs_cfg_if cfg ();

   logic               enabled;
   logic               reset_en;
   logic               stall_en;
   logic               int_en;
   logic               raw_int;
   logic               sys_reset;
   logic [31:0]        reload_value;
   logic [31:0]        count;
   wdlrs_state_t       state;
   wdlrs_state_t       next_state;
   logic               halt_s1;
   logic               halt_s2;

   // ==================================================
   // Lock and write gating
   wdlrs_lock u_lock (
      .mclk_in         (mclk_in),
      .rst_n_in        (rst_n_in),
      .ce_in           (ce_in),
      .lock_in         (lock_in),
      .unlock_in       (unlock_in),
      .enable_in       (enable_in),
      .reset_en_set_in (reset_en_set_in),
      .reset_en_clr_in (reset_en_clr_in),
      .stall_en_in     (stall_en_in),
      .int_en_in       (int_en_in),
      .reload_wr_in    (reload_wr_in),
      .reload_value_in (reload_value_in),
      .cfg             (cfg.gate)
   );

   // ==================================================
   // Debug halt comes from the core's clock tree; synchronise anyway
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         halt_s1 <= 1'b0;
         halt_s2 <= 1'b0;
      end else if (ce_in) begin
         halt_s1 <= debug_halt_in;
         halt_s2 <= halt_s1;
      end
   end

   // Decode of counting events
   wire   stalled    = stall_en & halt_s2;
   wire   tick       = enabled & ~stalled & ~cfg.reload_wr;
   wire   at_zero    = (count == WDLRS_ZERO);
   wire   timeout    = tick & at_zero;
   wire   zero_load  = cfg.reload_wr & (cfg.reload_val == WDLRS_ZERO) & enabled;
   wire   clear_now  = int_clear_in & ~timeout & ~zero_load;    // Set wins over clear

   // ==================================================
   // Configuration bits
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         enabled      <= WDLRS_EN_RST;
         reset_en     <= WDLRS_RSTEN_RST;
         stall_en     <= WDLRS_STALL_RST;
         int_en       <= WDLRS_IEN_RST;
         reload_value <= WDLRS_RELOAD_RST;
      end else if (ce_in) begin
         if (cfg.enable_wr) begin
            enabled <= 1'b1; // Enabling also arms the interrupt
            int_en  <= 1'b1;
         end else if (cfg.int_en_wr) begin
            int_en <= 1'b1;
         end
         if (cfg.reset_en_wr) begin
            reset_en <= cfg.reset_en_val;
         end
         if (cfg.stall_wr) begin
            stall_en <= 1'b1;
         end
         if (cfg.reload_wr) begin
            reload_value <= cfg.reload_val;
         end
      end
   end

   // ==================================================
   // Timeout stage machine
   always_comb begin
      next_state = state;
      case (state)
         WDLRS_IDLE: begin
            if (cfg.enable_wr) begin
               next_state = WDLRS_ARMED;
            end
         end
         WDLRS_ARMED: begin
            if (timeout || zero_load) begin
               next_state = WDLRS_FIRST;
            end
         end
         WDLRS_FIRST: begin
            if (clear_now) begin
               next_state = WDLRS_ARMED;
            end
         end
         default: begin
            next_state = WDLRS_IDLE;
         end
      endcase
   end

   // Counter, interrupt and reset; a reload write takes the counter at once
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         state     <= WDLRS_IDLE;
         count     <= WDLRS_COUNT_RST;
         raw_int   <= 1'b0;
         sys_reset <= 1'b0;
      end else if (ce_in) begin
         state <= next_state;
         if (cfg.reload_wr && enabled) begin
            count <= cfg.reload_val;
         end else if (cfg.reload_wr || (state == WDLRS_FIRST && clear_now)) begin
            count <= cfg.reload_wr ? cfg.reload_val : reload_value;
         end else if (timeout) begin
            count <= reload_value;
         end else if (tick) begin
            count <= count - WDLRS_ONE;
         end
         if (timeout || zero_load) begin
            raw_int <= 1'b1;
         end else if (int_clear_in) begin
            raw_int <= 1'b0;
         end
         if (timeout && state == WDLRS_FIRST && reset_en) begin
            sys_reset <= 1'b1;
         end
      end
   end

   // ==================================================
   // Software-visible status
   assign irq_out          = raw_int & int_en;
   assign int_status_out   = gated_status_select_in ? irq_out : raw_int;
   assign sys_reset_out    = sys_reset;
   assign locked_out       = cfg.locked;
   assign running_out      = enabled;
   assign reset_en_out     = reset_en;
   assign stall_en_out     = stall_en;
   assign reload_value_out = reload_value;
   assign count_out        = count;

   // ==================================================
   // Checks
   sequence first_pending;
      state == WDLRS_FIRST && raw_int;
   endsequence
   sequence second_zero;
      ce_in && timeout && reset_en;
   endsequence

   second_reset_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      first_pending ##0 second_zero |=> sys_reset_out) else $error("no reset");
   no_reset_off_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      !sys_reset_out && !reset_en |=> !sys_reset_out) else $error("reset while off");
   first_int_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      ce_in && timeout && state == WDLRS_ARMED |=> raw_int && count == reload_value)
      else $error("first timeout lost");
   count_down_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      ce_in && tick && !at_zero && !int_clear_in |=> count == $past(count) - WDLRS_ONE)
      else $error("count step wrong");
   stall_hold_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      ce_in && stalled && !cfg.reload_wr && !int_clear_in |=> $stable(count))
      else $error("counted while halted");
   reload_now_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      ce_in && cfg.reload_wr |=> count == $past(cfg.reload_val) && reload_value_out == count)
      else $error("reload not taken");
   zero_irq_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      ce_in && zero_load |=> int_status_out && irq_out)
      else $error("zero reload no irq");
   clear_reload_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      ce_in && state == WDLRS_FIRST && clear_now && !cfg.reload_wr |=>
      count == reload_value && state == WDLRS_ARMED) else $error("clear no reload");
   status_sel_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      int_status_out == (gated_status_select_in ? raw_int && int_en : raw_int))
      else $error("status select wrong");
endmodule

// File: core/wdlrs_pkg.sv
// Package: shared constants and types of the watchdog block
package wdlrs_pkg;
   // ==================================================
   // Widths and reset values
   localparam int          WDLRS_CNT_W      = 32;
   localparam logic [31:0] WDLRS_RELOAD_RST = 32'hFFFFFFFF;
   localparam logic [31:0] WDLRS_COUNT_RST  = 32'hFFFFFFFF;
   localparam logic [31:0] WDLRS_ZERO       = 32'h00000000;
   localparam logic [31:0] WDLRS_ONE        = 32'h00000001;
   localparam logic        WDLRS_LOCK_RST   = 1'b0;
   localparam logic        WDLRS_EN_RST     = 1'b0;
   localparam logic        WDLRS_RSTEN_RST  = 1'b0;
   localparam logic        WDLRS_STALL_RST  = 1'b0;
   localparam logic        WDLRS_IEN_RST    = 1'b0;

   // ==================================================
   // Timeout stage states, Gray along idle -> armed -> first timeout
   typedef enum logic [1:0] {
      WDLRS_IDLE  = 2'h0,
      WDLRS_ARMED = 2'h1,
      WDLRS_FIRST = 2'h3
   } wdlrs_state_t;
endpackage

// File: core/wdlrs_cfg_if.sv
// Interface: configuration write strobes qualified by the lock
`timescale 1ns/1ps
interface wdlrs_cfg_if;
   logic        enable_wr;
   logic        reset_en_wr;
   logic        reset_en_val;
   logic        stall_wr;
   logic        int_en_wr;
   logic        reload_wr;
   logic [31:0] reload_val;
   logic        locked;
   modport gate (output enable_wr, reset_en_wr, reset_en_val, stall_wr, int_en_wr,
                 reload_wr, reload_val, locked);
   modport core (input enable_wr, reset_en_wr, reset_en_val, stall_wr, int_en_wr,
                 reload_wr, reload_val, locked);
endinterface

// File: core/wdlrs_lock.sv
// Lock register and write gating for the configuration strobes
`timescale 1ns/1ps
module wdlrs_lock (
   input  wire logic  mclk_in,
   input  wire logic  rst_n_in,
   input  wire logic  ce_in,
   input  wire logic  lock_in,
   input  wire logic  unlock_in,
   input  wire logic  enable_in,
   input  wire logic  reset_en_set_in,
   input  wire logic  reset_en_clr_in,
   input  wire logic  stall_en_in,
   input  wire logic  int_en_in,
   input  wire logic  reload_wr_in,
   input  wire logic [31:0] reload_value_in,
   wdlrs_cfg_if.gate  cfg
);
   import wdlrs_pkg::*;
   logic locked;

   // ==================================================
   // Lock state; unlock wins over lock in the same cycle
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         locked <= WDLRS_LOCK_RST;
      end else if (ce_in) begin
         if (unlock_in) begin
            locked <= 1'b0;
         end else if (lock_in) begin
            locked <= 1'b1;
         end
      end
   end

   // Writes pass only while unlocked
   assign cfg.locked       = locked;
   assign cfg.enable_wr    = enable_in & ~locked;
   assign cfg.reset_en_wr  = (reset_en_set_in | reset_en_clr_in) & ~locked;
   assign cfg.reset_en_val = reset_en_set_in;
   assign cfg.stall_wr     = stall_en_in & ~locked;
   assign cfg.int_en_wr    = int_en_in & ~locked;
   assign cfg.reload_wr    = reload_wr_in & ~locked;
   assign cfg.reload_val   = reload_value_in;

   lock_blocks_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      locked |-> !cfg.reload_wr && !cfg.enable_wr) else $error("write passed lock");
   unlock_takes_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      ce_in && unlock_in |=> !locked) else $error("unlock ignored");
endmodule

// File: verif/wdlrs_dbg_model.sv
// Debug-halt source standing in for the processor core
`timescale 1ns/1ps
module wdlrs_dbg_model (
   input  wire logic mclk_in,
   input  wire logic halt_req_in,
   output logic      debug_halt_out
);
   // ==================================================
   // Halt level, raised for as long as the debugger holds the core
   initial debug_halt_out = 1'b0;
   always @(posedge mclk_in) begin
      debug_halt_out <= halt_req_in;
   end
endmodule

// File: verif/wdlrs_top_bench.sv
// Self-checking bench for the watchdog block
`timescale 1ns/1ps
module wdlrs_top_bench;
   import wdlrs_pkg::*;
   logic        mclk_in  = 1'b0;
   logic        rst_n_in = 1'b0;
   logic [8:0]  pv       = 9'h000;
   logic [31:0] rv       = 32'h00000000;
   logic        sel      = 1'b0;
   logic        hreq     = 1'b0;
   logic        ce       = 1'b1;
   logic        halt;
   logic        ist, irq, srst, lkd, run, ren, sten;
   logic [31:0] rvo, cnt, c0;
   int          n_mismatch      = 0;
   int          samples_checked = 0;

   // ==================================================
   // Clock, design and halt source
   initial begin
      forever #20 mclk_in = ~mclk_in;
   end
   wdlrs_dbg_model dbg (.mclk_in(mclk_in), .halt_req_in(hreq), .debug_halt_out(halt));
   wdlrs_top uut (
      .mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(ce),
      .lock_in(pv[0]), .unlock_in(pv[1]), .enable_in(pv[2]), .int_clear_in(pv[3]),
      .int_en_in(pv[4]), .reset_en_set_in(pv[5]), .reset_en_clr_in(pv[6]),
      .stall_en_in(pv[7]), .reload_wr_in(pv[8]), .reload_value_in(rv),
      .gated_status_select_in(sel), .debug_halt_in(halt),
      .int_status_out(ist), .irq_out(irq), .sys_reset_out(srst), .locked_out(lkd),
      .running_out(run), .reset_en_out(ren), .stall_en_out(sten),
      .reload_value_out(rvo), .count_out(cnt)
   );

   // ==================================================
   // Access tasks
   task automatic conclude;
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   // One-cycle strobe; reload data rides along with every strobe
   task automatic hit(input int k, input logic [31:0] v);
      @(posedge mclk_in) begin
         pv <= 9'h001 << k;
         rv <= v;
      end
      @(posedge mclk_in) pv <= 9'h000;
      #1;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask
   // Bounded wait on interrupt status (w=0) or system reset (w=1)
   task automatic wait_hi(input bit w, input int lim);
      for (int i = 0; i < lim && (w ? srst : ist) !== 1'b1; i++) tick(1);
      chk(w ? "sys_reset" : "int_status", 32'h00000001, w ? srst : ist);
   endtask

   // ==================================================
   // Watchdog on a hung run, far beyond the expected length
   initial begin
      #2000000;
      n_mismatch++;
      conclude();
   end

   // ==================================================
   // Test sequence
   initial begin
      repeat (4) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      #1;
      chk("locked", 32'h00000000, lkd);
      chk("running", 32'h00000000, run);
      chk("reset_en", 32'h00000000, ren);
      chk("stall_en", 32'h00000000, sten);
      chk("int_status", 32'h00000000, ist);
      chk("sys_reset", 32'h00000000, srst);
      chk("reload", WDLRS_RELOAD_RST, rvo);
      chk("count", WDLRS_COUNT_RST, cnt);
      hit(8, 32'h00000014);
      chk("reload", 32'h00000014, rvo);
      chk("count", 32'h00000014, cnt);
      hit(2, 32'h00000000);
      chk("running", 32'h00000001, run);
      c0 = cnt;
      tick(5);
      chk("count", c0 - 32'h00000005, cnt);
      wait_hi(1'b0, 40);
      chk("count", 32'h00000014, cnt);
      @(posedge mclk_in) sel <= 1'b1;
      #1;
      chk("gated status", 32'h00000001, ist);
      chk("irq", 32'h00000001, irq);
      hit(3, 32'h00000000);
      chk("int_status", 32'h00000000, ist);
      chk("count", 32'h00000014, cnt);
      // Second expiry with reset generation off must stay quiet
      wait_hi(1'b0, 40);
      tick(30);
      chk("sys_reset", 32'h00000000, srst);
      hit(3, 32'h00000000);
      hit(0, 32'h00000000);
      chk("locked", 32'h00000001, lkd);
      hit(8, 32'h00000007);
      chk("reload", 32'h00000014, rvo);
      hit(5, 32'h00000000);
      chk("reset_en", 32'h00000000, ren);
      hit(1, 32'h00000000);
      chk("locked", 32'h00000000, lkd);
      hit(4, 32'h00000000);
      hit(8, 32'h000003E8);
      chk("count", 32'h000003E8, cnt);
      hit(7, 32'h00000000);
      chk("stall_en", 32'h00000001, sten);
      // Clock enable low must freeze the counter; the launching edge still counts
      @(posedge mclk_in) ce <= 1'b0;
      #1;
      c0 = cnt;
      tick(5);
      chk("count frozen", c0, cnt);
      @(posedge mclk_in) ce <= 1'b1;
      // Halt reaches the counter a few cycles late through the synchroniser
      @(posedge mclk_in) hreq <= 1'b1;
      tick(6);
      c0 = cnt;
      tick(10);
      chk("count", c0, cnt);
      @(posedge mclk_in) hreq <= 1'b0;
      tick(6);
      c0 = cnt;
      tick(10);
      chk("count", c0 - 32'h0000000A, cnt);
      hit(3, 32'h00000000);
      hit(8, 32'h00000000);
      chk("int_status", 32'h00000001, ist);
      // Restart cleanly before arming reset, so the zero reload cannot trip it early
      hit(8, 32'h00000014);
      hit(3, 32'h00000000);
      chk("int_status", 32'h00000000, ist);
      hit(5, 32'h00000000);
      chk("reset_en", 32'h00000001, ren);
      hit(6, 32'h00000000);
      chk("reset_en", 32'h00000000, ren);
      hit(5, 32'h00000000);
      wait_hi(1'b0, 40);
      chk("sys_reset", 32'h00000000, srst);
      wait_hi(1'b1, 40);
      conclude();
   end
endmodule
